/* File: epp_pkg.sv */
// constants, register map and state types of the encoder post-processing block
package epp_pkg;
   // clock and time base
   localparam int CLK_PERIOD_NS = 20;
   localparam int NS_PER_MS = 1000000;
   localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
   localparam int QUAD_STEP_NS = 1000;
   localparam int QUAD_STEP_CYC = (QUAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CFG_EFFECT_MS = 1;
   // push detection times, in ms (one ms tick each), and the average shift
   localparam int PUSH_SLOPE_MS = 500;
   localparam int PUSH_MAX_MS = 10000;
   localparam int PUSH_MIN_NOM_MS = 10;
   localparam int PUSH_MIN_LPM2_MS = 40;
   localparam int PUSH_MIN_DEEPEST_LOW_POWER_STATE_MS = 150;
   localparam int RELAX_NOM_MS = 40;
   localparam int RELAX_DEEPEST_LOW_POWER_STATE_MS = 150;
   localparam int PULSE_MIN_MS = 40;
   localparam int PULSE_MAX_MS = 50;
   localparam int RECOVERY_MS = 5000;
   localparam int AVG_SHIFT = 6;
   // watchdog
   localparam int WD_TIME_MS = 60000;
   localparam logic [11:0] WD_WINDOW_LSB = 12'h004;
   // register byte offsets
   localparam logic [4:0] OFS_CONFIG = 5'h00;
   localparam logic [4:0] OFS_PUSH_THR = 5'h04;
   localparam logic [4:0] OFS_MIN_FIELD = 5'h08;
   localparam logic [4:0] OFS_STATUS = 5'h0c;
   localparam logic [4:0] OFS_ANGLE = 5'h10;
   localparam logic [4:0] OFS_IRQ_STS = 5'h14;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
   // config_word fields
   localparam int CFG_PM_LSB = 0;
   localparam int CFG_OUTPUT_HYSTERESIS_SEL_LSB = 2;
   localparam int CFG_SF_LSB = 4;
   localparam int CFG_FTH_LSB = 6;
   localparam int CFG_WD_BIT = 9;
   // status fields
   localparam int ST_MAG_BIT = 0;
   localparam int ST_PUSH_BIT = 1;
   localparam int ST_PS_LSB = 2;
   localparam int ST_FAST_BIT = 4;
   // interrupt status bits
   localparam int IRQ_PUSH_RISE = 0;
   localparam int IRQ_PUSH_FALL = 1;
   localparam int IRQ_MAG_LOST = 2;
   localparam int IRQ_WD_SLEEP = 3;
   // reset values
   localparam logic [9:0] CONFIG_RST = 10'h000;
   localparam logic [7:0] PUSH_THR_RST = 8'h20;
   localparam logic [7:0] MIN_FIELD_RST = 8'h10;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;
   // state types
   typedef enum logic [1:0] {
      PS_NOM = 2'b00,
      PS_LPM1 = 2'b01,
      PS_LPM2 = 2'b10,
      PS_DEEPEST_LOW_POWER_STATE = 2'b11
   } power_state_t;
   typedef enum logic [2:0] {
      P_IDLE = 3'b000,
      P_PRESS = 3'b001,
      P_HIGH = 3'b010,
      P_RELAX = 3'b011,
      P_RECOVER = 3'b100
   } push_state_t;
endpackage

/* File: encoder_post_processing.sv */
// angle filter, quadrature output, push detection and power modes of a rotary sensor
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - after startup, emit quadrature steps equal to the absolute angle, counting up
// - push output rises on fast field increase, falls on fast field decrease
// - threshold 0..255 applied over long average; crossing within 500 ms asserts push
// - slow field drift never makes a push; average follows the drift
// - push valid from 10/10/40/150 ms by mode up to 10000 ms
// - push pulse stays high at least 40 ms, at most 50 ms minimum
// - after a very long push, detection works again within 5000 ms
// - fast filter threshold code 000 leaves only the slow filter
// - slow filter code sets step delay 2.2, 1.1, 0.55, 0.286 ms
// - fast filter engages above slow-to-fast, leaves below fast-to-slow threshold
// - engaged fast filter acts as slow setting 11, then slow filter resumes
// - output hysteresis 1 to 3 LSB on the 12-bit angle
// - field below minimum level freezes quadrature and clears magnet present
// - state machine runs three low-power modes chosen by power mode select
// - any low-power mode disables the fast filter
// - watchdog drops to deepest mode after angle stays within 4 LSB one minute
// - new configuration reaches the outputs within 1 ms
module encoder_post_processing #(
   parameter int CYC_MS = epp_pkg::CYC_PER_MS,
   parameter int PUSH_MAX = epp_pkg::PUSH_MAX_MS,
   parameter int RECOVER = epp_pkg::RECOVERY_MS,
   parameter int WD_TIME = epp_pkg::WD_TIME_MS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // sensor front end
   input wire logic [11:0] angle_in,
   input wire logic angle_valid,
   input wire logic [7:0] field_in,
   // encoder outputs
   output logic quad_a,
   output logic quad_b,
   output logic push_out,
   output logic magnet_present_flag,
   output logic irq
);
   import epp_pkg::*;

   function automatic logic [11:0] abs_diff(input logic [11:0] a, input logic [11:0] b);
      logic [11:0] d;
      d = a - b;
      abs_diff = d[11] ? 12'(-d) : d;
   endfunction

   function automatic logic [11:0] fth_up(input logic [2:0] c);
      logic [11:0] v;
      v = 12'h000;
      unique case (c)
         3'b001: v = 12'h006;
         3'b010: v = 12'h007;
         3'b011: v = 12'h009;
         3'b100: v = 12'h012;
         3'b101: v = 12'h015;
         3'b110: v = 12'h018;
         3'b111: v = 12'h00a;
         default: v = 12'hfff;
      endcase
      fth_up = v;
   endfunction

   function automatic logic [11:0] fth_dn(input logic [2:0] c);
      logic [11:0] v;
      v = 12'h001;
      if (c[2] & c[1] & c[0]) begin
         v = 12'h004;
      end else if (c[2]) begin
         v = 12'h002;
      end
      fth_dn = v;
   endfunction

   // each code halves the time constant of the one before
   function automatic logic [2:0] sf_shift(input logic [1:0] c);
      sf_shift = 3'(3'h4 - {1'b0, c});
   endfunction

   // bus and registers
   logic waitrequest_r;
   logic [31:0] readdata_r;
   logic [9:0] cfg_r;
   logic [7:0] thr_r;
   logic [7:0] min_fld_r;
   logic [3:0] irq_sts_r;
   logic [3:0] irq_mask_r;
   logic irq_r;
   logic [31:0] rd_val;
   logic wr_acc;
   logic rd_acc;
   // time base
   logic [15:0] ms_cnt_r;
   logic ms_tick_r;
   // filter and angle
   logic [15:0] filt_r;
   logic primed_r;
   logic prime2_r;
   logic fast_eng_r;
   logic [11:0] ang_r;
   logic [15:0] filt_d;
   logic signed [15:0] filt_step;
   logic signed [15:0] filt_shr;
   logic [2:0] k_sel;
   logic [11:0] in_diff;
   logic fast_allowed;
   // magnet and quadrature
   logic magnet_r;
   logic [11:0] qpos_r;
   logic [7:0] qcnt_r;
   logic startup_r;
   logic quad_a_r;
   logic quad_b_r;
   logic [11:0] q_gap;
   // power and watchdog
   power_state_t power_state_r;
   logic [11:0] wd_ref_r;
   logic [15:0] wd_cnt_r;
   logic wd_hit;
   // push
   push_state_t push_state_r;
   logic push_r;
   logic [15:0] avg_r;
   logic [15:0] sl_cnt_r;
   logic [15:0] dur_cnt_r;
   logic [15:0] aux_cnt_r;
   logic signed [16:0] avg_d;
   logic signed [16:0] avg_step;
   logic [8:0] lvl;
   logic above;
   logic tracking;
   logic snap;
   logic [15:0] min_dur;
   logic [15:0] relax_gap;
   // event edges
   logic push_prev_r;
   logic mag_prev_r;
   logic deepest_low_power_state_prev_r;
   logic [3:0] ev;

   wire [1:0] pm_sel = cfg_r[CFG_PM_LSB +: 2];
   wire [1:0] output_hysteresis_sel_sel = cfg_r[CFG_OUTPUT_HYSTERESIS_SEL_LSB +: 2];
   wire [1:0] sf_sel = cfg_r[CFG_SF_LSB +: 2];
   wire [2:0] fth_sel = cfg_r[CFG_FTH_LSB +: 3];
   wire wd_en = cfg_r[CFG_WD_BIT];

   assign readdata = readdata_r;
   assign waitrequest = waitrequest_r;
   assign irq = irq_r;
   assign quad_a = quad_a_r;
   assign quad_b = quad_b_r;
   assign push_out = push_r;
   assign magnet_present_flag = magnet_r;

   // ---------------- avalon slave: one wait state per access ----------------
   assign wr_acc = write & ~waitrequest_r;
   assign rd_acc = read & ~waitrequest_r;

   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (address)
         OFS_CONFIG: rd_val[9:0] = cfg_r;
         OFS_PUSH_THR: rd_val[7:0] = thr_r;
         OFS_MIN_FIELD: rd_val[7:0] = min_fld_r;
         OFS_STATUS: begin
            rd_val[ST_MAG_BIT] = magnet_r;
            rd_val[ST_PUSH_BIT] = push_r;
            rd_val[ST_PS_LSB +: 2] = power_state_r;
            rd_val[ST_FAST_BIT] = fast_eng_r;
         end
         OFS_ANGLE: rd_val[11:0] = ang_r;
         OFS_IRQ_STS: rd_val[3:0] = irq_sts_r;
         OFS_IRQ_MASK: rd_val[3:0] = irq_mask_r;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest_r <= 1'b1;
         readdata_r <= 32'h0000_0000;
      end else if ((read | write) & waitrequest_r) begin
         waitrequest_r <= 1'b0;
         readdata_r <= read ? rd_val : 32'h0000_0000;
      end else begin
         waitrequest_r <= 1'b1;
      end
   end

   // settings act on the next clock, well inside the limit
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= CONFIG_RST;
         thr_r <= PUSH_THR_RST;
         min_fld_r <= MIN_FIELD_RST;
         irq_mask_r <= IRQ_MASK_RST;
      end else if (wr_acc) begin
         if (address == OFS_CONFIG && byteenable[0]) begin
            cfg_r[7:0] <= writedata[7:0];
         end
         if (address == OFS_CONFIG && byteenable[1]) begin
            cfg_r[9:8] <= writedata[9:8];
         end
         if (address == OFS_PUSH_THR && byteenable[0]) begin
            thr_r <= writedata[7:0];
         end
         if (address == OFS_MIN_FIELD && byteenable[0]) begin
            min_fld_r <= writedata[7:0];
         end
         if (address == OFS_IRQ_MASK && byteenable[0]) begin
            irq_mask_r <= writedata[3:0];
         end
      end
   end

   // ---------------- interrupts: read clears, a new event wins ----------------
   assign ev[IRQ_PUSH_RISE] = push_r & ~push_prev_r;
   assign ev[IRQ_PUSH_FALL] = ~push_r & push_prev_r;
   assign ev[IRQ_MAG_LOST] = ~magnet_r & mag_prev_r;
   assign ev[IRQ_WD_SLEEP] = (power_state_r == PS_DEEPEST_LOW_POWER_STATE) & ~deepest_low_power_state_prev_r & wd_hit;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_sts_r <= 4'h0;
         irq_r <= 1'b0;
         push_prev_r <= 1'b0;
         mag_prev_r <= 1'b0;
         deepest_low_power_state_prev_r <= 1'b0;
      end else begin
         irq_sts_r <= ((rd_acc && address == OFS_IRQ_STS) ? 4'h0 : irq_sts_r) | ev;
         irq_r <= |(irq_sts_r & irq_mask_r);
         push_prev_r <= push_r;
         mag_prev_r <= magnet_r;
         deepest_low_power_state_prev_r <= (power_state_r == PS_DEEPEST_LOW_POWER_STATE);
      end
   end

   // ---------------- 1 ms time base ----------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ms_cnt_r <= 16'h0000;
         ms_tick_r <= 1'b0;
      end else if (ms_cnt_r == 16'(CYC_MS - 1)) begin
         ms_cnt_r <= 16'h0000;
         ms_tick_r <= 1'b1;
      end else begin
         ms_cnt_r <= ms_cnt_r + 16'h0001;
         ms_tick_r <= 1'b0;
      end
   end

   // ---------------- angle filter ----------------
   // 12.4 fixed point; the modular difference keeps the wrap at 0/4095 smooth
   assign fast_allowed = (fth_sel != 3'b000) && (power_state_r == PS_NOM);
   assign k_sel = fast_eng_r ? sf_shift(2'b11) : sf_shift(sf_sel);
   assign filt_d = {angle_in, 4'h0} - filt_r;
   assign filt_shr = $signed(filt_d) >>> k_sel;
   // a step that shifts to nothing still creeps, or the output stalls one lsb low
   assign filt_step = (filt_shr == 16'sh0000 && filt_d != 16'h0000) ? 16'sh0001 : filt_shr;
   assign in_diff = abs_diff(angle_in, filt_r[15:4]);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_r <= 16'h0000;
         primed_r <= 1'b0;
      end else if (angle_valid) begin
         primed_r <= 1'b1;
         // first sample loads directly so startup does not chase a ramp
         filt_r <= primed_r ? filt_r + filt_step : {angle_in, 4'h0};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_eng_r <= 1'b0;
      end else if (!fast_allowed) begin
         fast_eng_r <= 1'b0;
      end else if (angle_valid && !fast_eng_r && in_diff > fth_up(fth_sel)) begin
         fast_eng_r <= 1'b1;
      end else if (angle_valid && fast_eng_r && in_diff < fth_dn(fth_sel)) begin
         fast_eng_r <= 1'b0;
      end
   end

   // output hysteresis: code equals the band in LSB
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ang_r <= 12'h000;
         prime2_r <= 1'b0;
      end else begin
         prime2_r <= primed_r;
         if (abs_diff(filt_r[15:4], ang_r) > {10'h000, output_hysteresis_sel_sel}) begin
            ang_r <= filt_r[15:4];
         end
      end
   end

   // ---------------- magnet detection ----------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         magnet_r <= 1'b0;
      end else begin
         magnet_r <= (field_in >= min_fld_r);
      end
   end

   // ---------------- quadrature output ----------------
   // startup counts only upward from zero so the host sees the absolute angle
   assign q_gap = ang_r - qpos_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         qpos_r <= 12'h000;
         qcnt_r <= 8'h00;
         startup_r <= 1'b1;
      end else begin
         qcnt_r <= (qcnt_r == 8'(QUAD_STEP_CYC - 1)) ? 8'h00 : qcnt_r + 8'h01;
         if (prime2_r && magnet_r && qpos_r == ang_r) begin
            startup_r <= 1'b0;
         end
         if (qcnt_r == 8'h00 && prime2_r && magnet_r && q_gap != 12'h000) begin
            if (startup_r || !q_gap[11]) begin
               qpos_r <= qpos_r + 12'h001;
            end else begin
               qpos_r <= qpos_r - 12'h001;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         quad_a_r <= 1'b0;
         quad_b_r <= 1'b0;
      end else begin
         quad_a_r <= qpos_r[1] ^ qpos_r[0];
         quad_b_r <= qpos_r[1];
      end
   end

   // ---------------- power modes and watchdog ----------------
   assign wd_hit = wd_en && (wd_cnt_r == 16'(WD_TIME));

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wd_ref_r <= 12'h000;
         wd_cnt_r <= 16'h0000;
      end else if (abs_diff(ang_r, wd_ref_r) > WD_WINDOW_LSB) begin
         wd_ref_r <= ang_r;
         wd_cnt_r <= 16'h0000;
      end else if (ms_tick_r && wd_cnt_r != 16'(WD_TIME)) begin
         wd_cnt_r <= wd_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_state_r <= PS_NOM;
      end else if (wd_hit) begin
         power_state_r <= PS_DEEPEST_LOW_POWER_STATE;
      end else begin
         unique case (pm_sel)
            2'b00: power_state_r <= PS_NOM;
            2'b01: power_state_r <= PS_LPM1;
            2'b10: power_state_r <= PS_LPM2;
            2'b11: power_state_r <= PS_DEEPEST_LOW_POWER_STATE;
         endcase
      end
   end

   // ---------------- push detection ----------------
   always_comb begin
      min_dur = 16'(PUSH_MIN_NOM_MS);
      relax_gap = 16'(RELAX_NOM_MS);
      unique case (power_state_r)
         PS_NOM, PS_LPM1: min_dur = 16'(PUSH_MIN_NOM_MS);
         PS_LPM2: min_dur = 16'(PUSH_MIN_LPM2_MS);
         PS_DEEPEST_LOW_POWER_STATE: begin
            min_dur = 16'(PUSH_MIN_DEEPEST_LOW_POWER_STATE_MS);
            relax_gap = 16'(RELAX_DEEPEST_LOW_POWER_STATE_MS);
         end
      endcase
   end

   // average is frozen while pressed so the press cannot erase itself
   assign tracking = (push_state_r == P_IDLE) || (push_state_r == P_RELAX) || (push_state_r == P_RECOVER);
   assign avg_d = $signed({1'b0, field_in, 8'h00}) - $signed({1'b0, avg_r});
   assign avg_step = avg_d >>> AVG_SHIFT;
   assign lvl = {1'b0, avg_r[15:8]} + {1'b0, thr_r};
   assign above = {1'b0, field_in} > lvl;
   assign snap = (push_state_r == P_RECOVER) && (aux_cnt_r >= 16'(RECOVER));

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         avg_r <= 16'h0000;
      end else if (snap) begin
         avg_r <= {field_in, 8'h00};
      end else if (ms_tick_r && tracking) begin
         avg_r <= avg_r + avg_step[15:0];
      end
   end

   // ms since the field was last at or under the rounded average; truncated it stalls below
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sl_cnt_r <= 16'h0000;
      end else if ({1'b0, field_in} <= {1'b0, avg_r[15:8]} + {8'h00, avg_r[7]}) begin
         sl_cnt_r <= 16'h0000;
      end else if (ms_tick_r && sl_cnt_r <= 16'(PUSH_SLOPE_MS)) begin
         sl_cnt_r <= sl_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         push_state_r <= P_IDLE;
         push_r <= 1'b0;
         dur_cnt_r <= 16'h0000;
         aux_cnt_r <= 16'h0000;
      end else begin
         if (ms_tick_r) begin
            dur_cnt_r <= dur_cnt_r + 16'h0001;
            aux_cnt_r <= aux_cnt_r + 16'h0001;
         end
         unique case (push_state_r)
            P_IDLE: begin
               dur_cnt_r <= 16'h0000;
               // a slow crossing is left to the average to absorb
               if (above && sl_cnt_r <= 16'(PUSH_SLOPE_MS)) begin
                  push_state_r <= P_PRESS;
               end
            end
            P_PRESS: begin
               aux_cnt_r <= 16'h0000;
               if (!above) begin
                  push_state_r <= P_IDLE;
               end else if (dur_cnt_r >= min_dur) begin
                  push_state_r <= P_HIGH;
                  push_r <= 1'b1;
               end
            end
            P_HIGH: begin
               if (dur_cnt_r >= 16'(PUSH_MAX)) begin
                  push_state_r <= P_RECOVER;
                  push_r <= 1'b0;
                  aux_cnt_r <= 16'h0000;
               end else if (!above && aux_cnt_r >= 16'(PULSE_MIN_MS)) begin
                  push_state_r <= P_RELAX;
                  push_r <= 1'b0;
                  aux_cnt_r <= 16'h0000;
               end
            end
            P_RELAX: begin
               if (aux_cnt_r >= relax_gap) begin
                  push_state_r <= P_IDLE;
               end
            end
            P_RECOVER: begin
               if (!above || snap) begin
                  push_state_r <= P_IDLE;
               end
            end
            default: begin
               push_state_r <= P_IDLE;
               push_r <= 1'b0;
            end
         endcase
      end
   end

endmodule

/* File: epp_checker_assertions.sv */
// port-level assertions of the encoder post-processing block
`timescale 1ns/1ps
module epp_checker #(
   parameter int CYC_MS = 50,
   parameter int PUSH_MAX = 200
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bus
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // outputs
   input wire logic quad_a,
   input wire logic quad_b,
   input wire logic push_out,
   input wire logic magnet_present_flag,
   input wire logic irq
);
   import epp_pkg::*;
   logic qa_r;
   logic qb_r;
   logic acc_r;
   logic [7:0] gap_r;
   logic [31:0] high_r;
   logic moved;
   assign moved = (quad_a != qa_r) || (quad_b != qb_r);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // edges since the last visible quadrature move, saturating
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         qa_r <= 1'h0;
         qb_r <= 1'h0;
         gap_r <= 8'hff;
      end else begin
         qa_r <= quad_a;
         qb_r <= quad_b;
         if (moved) gap_r <= 8'h00;
         else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
      end
   end
   // push high time in cycles; acknowledged access, one edge late
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         high_r <= 32'h0;
         acc_r <= 1'h0;
      end else begin
         high_r <= push_out ? high_r + 32'h1 : 32'h0;
         acc_r <= !waitrequest && (read || write);
      end
   end
   wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait cycle");
   ack_pulse_a: assert property (!waitrequest |=> waitrequest)
      else $error("acknowledge longer than one cycle");
   idle_wait_a: assert property (!read && !write |=> waitrequest)
      else $error("acknowledge without request");
   rdata_hold_a: assert property (!read && !write |=> $stable(readdata))
      else $error("read data changed without access");
   quad_gray_a: assert property (!(quad_a != qa_r && quad_b != qb_r))
      else $error("both quadrature lines moved together");
   quad_gap_a: assert property (moved |-> gap_r >= QUAD_STEP_CYC - 1)
      else $error("quadrature steps too close");
   mag_freeze_a: assert property (!magnet_present_flag [*2] |=> $stable(quad_a) && $stable(quad_b))
      else $error("quadrature moved without magnet");
   pulse_min_a: assert property ($fell(push_out) |-> high_r >= (PULSE_MIN_MS - 1) * CYC_MS)
      else $error("push pulse too short");
   pulse_max_a: assert property (push_out |-> high_r <= (PUSH_MAX + 1) * CYC_MS)
      else $error("push held past maximum");
   irq_clear_a: assert property ($fell(irq) |-> $past(acc_r))
      else $error("interrupt dropped without register access");
endmodule
bind encoder_post_processing epp_checker #(.CYC_MS(CYC_MS), .PUSH_MAX(PUSH_MAX)) chk_u (
   .sys_clk(sys_clk), .rst_n(rst_n), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .quad_a(quad_a), .quad_b(quad_b), .push_out(push_out),
   .magnet_present_flag(magnet_present_flag), .irq(irq));

/* File: host_counter.sv */
// host model: quadrature position counter and push edge counter
`timescale 1ns/1ps
module host_counter (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // encoder lines
   input wire logic quad_a,
   input wire logic quad_b,
   input wire logic push_out,
   // host view
   output logic signed [15:0] pos,
   output logic [7:0] rises
);
   logic [1:0] idx_r;
   logic push_r;
   logic [1:0] idx;
   logic [1:0] dif;
   assign idx = {quad_b, quad_a ^ quad_b};
   assign dif = idx - idx_r;
   // counting from zero after start yields the absolute angle; a double step is lost
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_r <= 2'h0;
         pos <= 16'sh0;
      end else begin
         idx_r <= idx;
         if (dif == 2'h1) pos <= pos + 16'sh1;
         else if (dif == 2'h3) pos <= pos - 16'sh1;
      end
   end
   // host sees each press once
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         push_r <= 1'h0;
         rises <= 8'h00;
      end else begin
         push_r <= push_out;
         if (push_out && !push_r) rises <= rises + 8'h01;
      end
   end
endmodule

/* File: testbench.sv */
// self-checking bench of the encoder post-processing block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module testbench;
   import epp_pkg::*;
   localparam int CMS = 50;
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic [4:0] address = 5'h00;
   logic read = 1'h0;
   logic write = 1'h0;
   logic [3:0] byteenable = 4'hf;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic [11:0] angle_in = 12'h000;
   logic angle_valid = 1'h0;
   logic [7:0] field_in = 8'h18;
   logic quad_a;
   logic quad_b;
   logic push_out;
   logic magnet_present_flag;
   logic irq;
   logic signed [15:0] pos;
   logic [7:0] rises;
   logic [31:0] rd;
   int mismatches = 0;
   int checks = 0;
   int n;
   int cyc = 0;
   encoder_post_processing #(.CYC_MS(CMS), .PUSH_MAX(200), .RECOVER(100), .WD_TIME(50)) dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .angle_in(angle_in), .angle_valid(angle_valid), .field_in(field_in), .quad_a(quad_a),
      .quad_b(quad_b), .push_out(push_out), .magnet_present_flag(magnet_present_flag), .irq(irq));
   host_counter host_u (.sys_clk(sys_clk), .rst_n(rst_n), .quad_a(quad_a), .quad_b(quad_b),
      .push_out(push_out), .pos(pos), .rises(rises));
   initial begin
      forever #10 sys_clk = !sys_clk;
   end
   task finish_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         finish_test;
      end
   end
   // request held until the edge that samples waitrequest low
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= d;
      do begin
         @(posedge sys_clk);
      end while (waitrequest !== 1'h0);
      rd = readdata;
      read <= 1'h0;
      write <= 1'h0;
   endtask
   task rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      `CHK(rd & m, e)
   endtask
   task wait_ms(input int ms);
      repeat (ms * CMS) @(posedge sys_clk);
   endtask
   task until_push(input logic lvl, input int lim);
      n = 0;
      while (push_out !== lvl && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'h1;
      rd_chk(OFS_CONFIG, 32'hffffffff, 32'h0);
      rd_chk(OFS_PUSH_THR, 32'hffffffff, 32'h20);
      rd_chk(OFS_MIN_FIELD, 32'hffffffff, 32'h10);
      rd_chk(OFS_IRQ_MASK, 32'hffffffff, 32'h0);
      rd_chk(OFS_STATUS, 32'h0c, 32'h0);
      bus(1'h1, 5'h1c, 32'h5a);
      rd_chk(5'h1c, 32'hffffffff, 32'h0);
      bus(1'h1, OFS_PUSH_THR, 32'h1ff);
      rd_chk(OFS_PUSH_THR, 32'hffffffff, 32'hff);
      bus(1'h1, OFS_PUSH_THR, 32'h20);
      $display("test registers done");
      angle_in <= 12'h008;
      angle_valid <= 1'h1;
      repeat (1000) @(posedge sys_clk);
      `CHK(pos, 16'sh0008)
      `CHK(magnet_present_flag, 1'h1)
      field_in <= 8'h08;
      angle_in <= 12'h028;
      repeat (1000) @(posedge sys_clk);
      `CHK(pos, 16'sh0008)
      `CHK(magnet_present_flag, 1'h0)
      rd_chk(OFS_STATUS, 32'h1, 32'h0);
      rd_chk(OFS_IRQ_STS, 32'h4, 32'h4);
      field_in <= 8'h18;
      repeat (2000) @(posedge sys_clk);
      `CHK(pos > 16'sh0008, 1'h1)
      bus(1'h1, OFS_CONFIG, 32'hc);
      angle_in <= 12'h02b;
      wait_ms(1);
      rd_chk(OFS_ANGLE, 32'hfff, 32'h28);
      angle_in <= 12'h02c;
      wait_ms(1);
      rd_chk(OFS_ANGLE, 32'hfff, 32'h2c);
      bus(1'h1, OFS_CONFIG, 32'h4c);
      angle_in <= 12'h06c;
      rd_chk(OFS_STATUS, 32'h10, 32'h10);
      wait_ms(1);
      rd_chk(OFS_STATUS, 32'h10, 32'h0);
      bus(1'h1, OFS_CONFIG, 32'h4d);
      rd_chk(OFS_STATUS, 32'h1c, 32'h4);
      angle_in <= 12'h02c;
      rd_chk(OFS_STATUS, 32'h10, 32'h0);
      bus(1'h1, OFS_CONFIG, 32'hc);
      angle_in <= 12'h06c;
      rd_chk(OFS_STATUS, 32'h10, 32'h0);
      $display("test position done");
      bus(1'h1, OFS_IRQ_MASK, 32'h3);
      bus(1'h0, OFS_IRQ_STS, 32'h0);
      field_in <= 8'h60;
      until_push(1'h1, 30 * CMS);
      `CHK(n >= 9 * CMS && n <= 12 * CMS, 1'h1)
      repeat (2) @(posedge sys_clk);
      `CHK(irq, 1'h1)
      field_in <= 8'h18;
      until_push(1'h0, 60 * CMS);
      `CHK(n >= 39 * CMS && n <= 51 * CMS, 1'h1)
      rd_chk(OFS_IRQ_STS, 32'hf, 32'h3);
      repeat (2) @(posedge sys_clk);
      `CHK(irq, 1'h0)
      `CHK(rises, 8'h01)
      $display("test push done");
      // gap before the next press
      wait_ms(160);
      bus(1'h1, OFS_CONFIG, 32'h3);
      wait_ms(2);
      rd_chk(OFS_STATUS, 32'h0c, 32'h0c);
      field_in <= 8'h60;
      wait_ms(100);
      `CHK(push_out, 1'h0)
      until_push(1'h1, 80 * CMS);
      `CHK(push_out, 1'h1)
      field_in <= 8'h18;
      until_push(1'h0, 60 * CMS);
      `CHK(push_out, 1'h0)
      $display("test deep mode done");
      bus(1'h1, OFS_CONFIG, 32'h200);
      angle_in <= 12'h100;
      wait_ms(2);
      rd_chk(OFS_STATUS, 32'h0c, 32'h0);
      wait_ms(55);
      rd_chk(OFS_STATUS, 32'h0c, 32'h0c);
      rd_chk(OFS_IRQ_STS, 32'h8, 32'h8);
      $display("test watchdog done");
      finish_test;
   end
endmodule
